// ---- hdl/cahb_wrapper.v ----
// Purpose: Bridge a 32-bit core's memory requests onto a bus as master.
// Assumes: Core and bus share core_clk; data buses bypass this block.
// Notes:   One transfer in flight at a time; the core is stalled meanwhile.
//
// Overview of operation
// - Active low bus reset returns all master state to idle.
// - Bus ownership only gained where ready and grant are both high.
// - Act on each of OKAY, ERROR, RETRY and SPLIT responses.
// - Drive a full 32-bit byte address for every transfer.
// - Only idle, nonsequential or sequential types; never busy.
// - Direction output high for write, low for read.
// - Transfer size byte, halfword or word matching the core width.
// - Bursts are marked as undefined-length incrementing.
// - Protection shows opcode or data and privileged or user.
// - Request the bus whenever a transfer is needed.
// - Lock held high keeps other masters off until it falls.
// - Access kind bit 0 selects data, bit 1 selects privileged.
// - Core width 00 byte, 01 halfword, 10 word, 11 reserved.
// - Core cycle 00 internal, 01 coprocessor, 10 nonseq, 11 seq.
// - Core write high is a write cycle, passed to the bus.
// - Core lock high keeps the access locked until it falls.
// - Abort the core when an access is refused by error response.
// - Stall the core with clock enable low during bus waits.
// - Core clock is bus clock; data buses connect directly.
// - Idle 00, nonseq 10, seq 11, burst 001, cache bits zero.
// - One extra wait per unlocked nonseq access, two on a swap read.
// - Hold and reissue transfers after split, retry or grant loss.

`timescale 1ns/10ps
`include "cahb_wrapper_regs.vh"

module cahb_wrapper (
    core_clk,
    bus_reset_n,
    hready,
    hresp,
    hgrant,
    core_addr,
    core_access_kind,
    core_size,
    core_trans,
    core_write,
    core_lock,
    haddr,
    htrans,
    hwrite,
    hsize,
    hburst,
    hprot,
    hbusreq,
    hlock,
    core_stall_n,
    core_abort,
    core_reset_low
);

    input  wire        core_clk;
    input  wire        bus_reset_n;
    input  wire        hready;
    input  wire [1:0]  hresp;
    input  wire        hgrant;
    input  wire [31:0] core_addr;
    input  wire [1:0]  core_access_kind;
    input  wire [1:0]  core_size;
    input  wire [1:0]  core_trans;
    input  wire        core_write;
    input  wire        core_lock;
    output reg  [31:0] haddr;
    output reg  [1:0]  htrans;
    output reg         hwrite;
    output reg  [2:0]  hsize;
    output reg  [2:0]  hburst;
    output reg  [3:0]  hprot;
    output reg         hbusreq;
    output reg         hlock;
    output reg         core_stall_n;
    output reg         core_abort;
    output reg         core_reset_low;

    // One-hot states.
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_WAIT = 5'h02;
    localparam [4:0] ST_ADDR = 5'h04;
    localparam [4:0] ST_DATA = 5'h08;
    localparam [4:0] ST_HOLD = 5'h10;

    reg [4:0]  state_reg;
    reg [4:0]  state_next;
    reg [1:0]  wait_cnt_reg;
    reg [1:0]  wait_cnt_next;
    reg        owner_reg;
    reg        owner_next;
    reg        last_ok_reg;
    reg        last_ok_next;
    reg        req_seq_reg;
    reg        req_seq_next;
    reg [31:0] haddr_next;
    reg [1:0]  htrans_next;
    reg        hwrite_next;
    reg [2:0]  hsize_next;
    reg [2:0]  hburst_next;
    reg [3:0]  hprot_next;
    reg        hbusreq_next;
    reg        hlock_next;
    reg        core_stall_n_next;
    reg        core_abort_next;

    // width decode
    // The reserved width code is issued as a word so the bus never sees
    // an illegal size; the core does not produce it in normal operation.
    function [2:0] cahb_size;
        input [1:0] csize;
        begin
            case (csize)
                `CAHB_CSIZE_BYTE: cahb_size = `CAHB_HSIZE_BYTE;
                `CAHB_CSIZE_HALF: cahb_size = `CAHB_HSIZE_HALF;
                `CAHB_CSIZE_WORD: cahb_size = `CAHB_HSIZE_WORD;
                default:          cahb_size = `CAHB_HSIZE_WORD;
            endcase
        end
    endfunction

    function [3:0] cahb_prot;
        input [1:0] kind;
        begin
            cahb_prot = {`CAHB_PROT_CB,
                         kind[`CAHB_KIND_PRIV_BIT],
                         kind[`CAHB_KIND_DATA_BIT]};
        end
    endfunction

    // Address phase type: active only while this master owns the bus.
    function [1:0] cahb_active;
        input owned;
        input seq;
        begin
            if (!owned) begin
                cahb_active = `CAHB_TRANS_IDLE;
            end else if (seq) begin
                cahb_active = `CAHB_TRANS_SEQ;
            end else begin
                cahb_active = `CAHB_TRANS_NONSEQ;
            end
        end
    endfunction

    always @* begin
        state_next        = state_reg;
        wait_cnt_next     = wait_cnt_reg;
        last_ok_next      = last_ok_reg;
        req_seq_next      = req_seq_reg;
        haddr_next        = haddr;
        htrans_next       = `CAHB_TRANS_IDLE;
        hwrite_next       = hwrite;
        hsize_next        = hsize;
        hburst_next       = hburst;
        hprot_next        = hprot;
        hbusreq_next      = hbusreq;
        hlock_next        = hlock;
        core_stall_n_next = core_stall_n;
        core_abort_next   = 1'b0;

        owner_next = hready ? hgrant : owner_reg;

        case (state_reg)
            ST_IDLE: begin
                // The core advances at this edge and shows its next cycle.
                // lock follows core
                hlock_next = core_lock;
                if (core_trans[`CAHB_CTRANS_MEM_BIT]) begin
                    haddr_next = core_addr;
                    hwrite_next = core_write;
                    hsize_next = cahb_size(core_size);
                    hprot_next = cahb_prot(core_access_kind);
                    hburst_next = `CAHB_BURST_INCR;
                    req_seq_next = core_trans[`CAHB_CTRANS_SEQ_BIT] &
                                   last_ok_reg;
                    hbusreq_next = 1'b1;
                    core_stall_n_next = 1'b0;
                    // extra wait states
                    // A swap read gets its lock out two cycles before the
                    // bus access so the arbiter can honour it in time.
                    if (core_lock && !hlock && !core_write) begin
                        wait_cnt_next = `CAHB_WS_SWAP;
                        state_next    = ST_WAIT;
                    end else if (!core_lock &&
                                 !(core_trans[`CAHB_CTRANS_SEQ_BIT] &&
                                   last_ok_reg)) begin
                        wait_cnt_next = `CAHB_WS_NONSEQ;
                        state_next    = ST_WAIT;
                    end else begin
                        wait_cnt_next = `CAHB_WS_NONE;
                        state_next    = ST_ADDR;
                        htrans_next   = cahb_active(owner_next,
                            core_trans[`CAHB_CTRANS_SEQ_BIT] & last_ok_reg);
                    end
                end else begin
                    htrans_next  = `CAHB_TRANS_IDLE;
                    hburst_next  = `CAHB_BURST_SINGLE;
                    hbusreq_next = core_lock;
                    last_ok_next = 1'b0;
                end
            end

            ST_WAIT: begin
                // The bus is requested early so grant can arrive meanwhile.
                if (wait_cnt_reg == `CAHB_WS_LAST) begin
                    state_next  = ST_ADDR;
                    htrans_next = cahb_active(owner_next, req_seq_reg);
                end
                wait_cnt_next = wait_cnt_reg - `CAHB_WS_LAST;
            end

            ST_ADDR: begin
                // wait out grant loss
                // An address phase only counts when it was driven while
                // owning the bus; otherwise the held request is re-driven.
                if (hready && htrans != `CAHB_TRANS_IDLE) begin
                    state_next   = ST_DATA;
                    htrans_next  = `CAHB_TRANS_IDLE;
                    hbusreq_next = 1'b0;
                end else begin
                    htrans_next = cahb_active(owner_next, req_seq_reg);
                end
            end

            ST_DATA: begin
                if (hready) begin
                    state_next        = ST_IDLE;
                    core_stall_n_next = 1'b1;
                    if (hresp == `CAHB_RESP_OKAY) begin
                        last_ok_next = 1'b1;
                    end else begin
                        core_abort_next = 1'b1;
                        last_ok_next    = 1'b0;
                    end
                end else if (hresp == `CAHB_RESP_RETRY ||
                             hresp == `CAHB_RESP_SPLIT) begin
                    state_next   = ST_HOLD;
                    req_seq_next = 1'b0;
                    last_ok_next = 1'b0;
                    hbusreq_next = 1'b1;
                end
            end

            ST_HOLD: begin
                // reissue when owned
                // This is the second response cycle; the held transfer is
                // re-driven as nonsequential once ownership returns.
                state_next  = ST_ADDR;
                htrans_next = cahb_active(owner_next, 1'b0);
            end

            default: begin
                state_next        = ST_IDLE;
                htrans_next       = `CAHB_TRANS_IDLE;
                hbusreq_next      = 1'b0;
                core_stall_n_next = 1'b1;
            end
        endcase
    end

    always @(posedge core_clk or negedge bus_reset_n) begin
        if (!bus_reset_n) begin
            state_reg      <= ST_IDLE;
            wait_cnt_reg   <= `CAHB_WS_NONE;
            owner_reg      <= 1'b0;
            last_ok_reg    <= 1'b0;
            req_seq_reg    <= 1'b0;
            haddr          <= `CAHB_ADDR_RST;
            htrans         <= `CAHB_TRANS_IDLE;
            hwrite         <= 1'b0;
            hsize          <= `CAHB_HSIZE_BYTE;
            hburst         <= `CAHB_BURST_SINGLE;
            hprot          <= {`CAHB_PROT_CB, 2'h0};
            hbusreq        <= 1'b0;
            hlock          <= 1'b0;
            core_stall_n   <= 1'b1;
            core_abort     <= 1'b0;
            core_reset_low <= 1'b0;
        end else begin
            state_reg      <= state_next;
            wait_cnt_reg   <= wait_cnt_next;
            owner_reg      <= owner_next;
            last_ok_reg    <= last_ok_next;
            req_seq_reg    <= req_seq_next;
            haddr          <= haddr_next;
            htrans         <= htrans_next;
            hwrite         <= hwrite_next;
            hsize          <= hsize_next;
            hburst         <= hburst_next;
            hprot          <= hprot_next;
            hbusreq        <= hbusreq_next;
            hlock          <= hlock_next;
            core_stall_n   <= core_stall_n_next;
            core_abort     <= core_abort_next;
            // core leaves reset with the bus
            core_reset_low <= 1'b1;
        end
    end

endmodule // cahb_wrapper

// ---- hdl/cahb_wrapper_regs.vh ----
// Purpose: Named constants for the core to bus master wrapper.
// Assumes: Included by cahb_wrapper.v only; definitions only.
// Notes:   Bus encodings follow the published bus protocol.
`ifndef CAHB_WRAPPER_REGS_VH
`define CAHB_WRAPPER_REGS_VH

// Bus transfer types.
`define CAHB_TRANS_IDLE     2'h0
`define CAHB_TRANS_NONSEQ   2'h2
`define CAHB_TRANS_SEQ      2'h3

// Bus responses.
`define CAHB_RESP_OKAY      2'h0
`define CAHB_RESP_ERROR     2'h1
`define CAHB_RESP_RETRY     2'h2
`define CAHB_RESP_SPLIT     2'h3

// Burst types.
`define CAHB_BURST_SINGLE   3'h0
`define CAHB_BURST_INCR     3'h1

// Bus transfer sizes.
`define CAHB_HSIZE_BYTE     3'h0
`define CAHB_HSIZE_HALF     3'h1
`define CAHB_HSIZE_WORD     3'h2

// Core width codes.
`define CAHB_CSIZE_BYTE     2'h0
`define CAHB_CSIZE_HALF     2'h1
`define CAHB_CSIZE_WORD     2'h2

// Core access kind bit positions.
`define CAHB_KIND_DATA_BIT  0
`define CAHB_KIND_PRIV_BIT  1

// Core cycle type bit positions: bit 1 memory, bit 0 sequential.
`define CAHB_CTRANS_MEM_BIT 1
`define CAHB_CTRANS_SEQ_BIT 0

// Cacheable and bufferable protection bits.
`define CAHB_PROT_CB        2'h0

// Extra wait states inserted ahead of an access.
`define CAHB_WS_NONE        2'h0
`define CAHB_WS_NONSEQ      2'h1
`define CAHB_WS_SWAP        2'h2
`define CAHB_WS_LAST        2'h1

// Reset values.
`define CAHB_ADDR_RST       32'h0000_0000

`endif

// ---- verification/cahb_bus_model.sv ----
// Purpose: Arbiter and slave standing on the wrapper's bus side.
// Assumes: Single master; responses latched when an address is taken.
// Notes:   A non-OKAY answer always gets its two-cycle form.
`timescale 1ns/10ps
module cahb_bus_model (
    input  wire       hclk,
    input  wire       hresetn,
    input  wire [1:0] htrans,
    input  wire       hlock,
    input  wire       gnt_req,
    input  wire [3:0] waits,
    input  wire [1:0] resp_sel,
    output wire       hready,
    output wire [1:0] hresp,
    output wire       hgrant
);
    logic       dph;
    logic [3:0] n, w;
    logic [1:0] r;
    assign hgrant = gnt_req | hlock;
    assign hready = !dph || n >= w;
    assign hresp  = (dph && n + 4'h1 >= w) ? r : 2'h0;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph <= 1'b0;
            n <= 4'h0;
            w <= 4'h0;
            r <= 2'h0;
        end else if (hready && htrans[1]) begin
            dph <= 1'b1;
            n <= 4'h0;
            r <= resp_sel;
            w <= (resp_sel != 2'h0 && waits == 4'h0) ? 4'h1 : waits;
        end else if (hready) begin
            dph <= 1'b0;
        end else begin
            n <= n + 4'h1;
        end
    end
endmodule // cahb_bus_model

// ---- verification/cahb_wrapper_properties.sv ----
// Purpose: Concurrent checks on the core to bus master wrapper ports.
// Assumes: One clock domain; bound to every wrapper instance.
// Notes:   The data phase flag is rebuilt here from the bus signals.
`timescale 1ns/10ps
module cahb_wrapper_properties (
    input wire        core_clk,
    input wire        bus_reset_n,
    input wire        hready,
    input wire [1:0]  hresp,
    input wire        hgrant,
    input wire [1:0]  htrans,
    input wire [2:0]  hburst,
    input wire [3:0]  hprot,
    input wire        hbusreq,
    input wire        hlock,
    input wire        core_stall_n,
    input wire        core_abort,
    input wire        core_reset_low
);
    reg  dph_reg;
    wire dph_next = hready ? htrans[1] : dph_reg;
    wire fin      = dph_reg && hready;
    always @(posedge core_clk or negedge bus_reset_n) begin
        if (!bus_reset_n) begin
            dph_reg <= 1'b0;
        end else begin
            dph_reg <= dph_next;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!bus_reset_n);
    a_trans_legal: assert property (htrans != 2'h1)
        else $error("busy transfer type driven");
    a_prot_cache: assert property (hprot[3:2] == 2'h0)
        else $error("cache protection bits set");
    a_burst_incr: assert property (htrans[1] |-> hburst == 3'h1)
        else $error("active transfer not incrementing");
    a_own_grant: assert property ($rose(htrans[1]) |->
        $past(hgrant && hready))
        else $error("transfer started without ownership");
    a_busreq_hold: assert property (hbusreq && !hgrant |=> hbusreq)
        else $error("request dropped before grant");
    a_stall_data: assert property (htrans[1] && hready |=> !core_stall_n)
        else $error("core not stalled in data phase");
    a_stall_release: assert property (fin && !hresp[1] |=> core_stall_n)
        else $error("core not released after completion");
    a_abort_error: assert property (fin && hresp == 2'h1 |=> core_abort)
        else $error("no abort after error");
    a_abort_cause: assert property ($rose(core_abort) |->
        $past(fin && hresp == 2'h1))
        else $error("abort without error");
    // The reissued address is driven right after the second response cycle
    // when ownership is kept, so the window opens at the very next cycle.
    a_retry_reissue: assert property (fin && hresp[1] |=> ##[0:20]
        (htrans == 2'h2 && !core_stall_n))
        else $error("refused transfer not reissued");
    a_lock_ahead: assert property ($rose(hlock) |-> !htrans[1])
        else $error("lock not raised ahead of access");
    // The reset must have been seen at the edge before, so the outputs
    // are not judged before the asynchronous reset has reached them.
    a_reset_idle: assert property (disable iff (1'b0)
        !bus_reset_n && $past(!bus_reset_n) |-> htrans == 2'h0 && !hbusreq
        && !hlock && core_stall_n && !core_reset_low)
        else $error("outputs not idle in reset");
    c_error: cover property (fin && hresp == 2'h1);
    c_retry: cover property (fin && hresp[1]);
    c_seq: cover property (htrans == 2'h3);
    c_lock: cover property (hlock && htrans[1]);
endmodule // cahb_wrapper_properties
bind cahb_wrapper cahb_wrapper_properties cahb_wrapper_properties_i (
    .core_clk(core_clk), .bus_reset_n(bus_reset_n), .hready(hready),
    .hresp(hresp), .hgrant(hgrant), .htrans(htrans), .hburst(hburst),
    .hprot(hprot), .hbusreq(hbusreq), .hlock(hlock),
    .core_stall_n(core_stall_n), .core_abort(core_abort),
    .core_reset_low(core_reset_low));

// ---- verification/cahb_wrapper_tb_top.sv ----
// Purpose: Self-checking bench for the core to bus master wrapper.
// Assumes: The bus model answers; a queue holds expected phases.
// Notes:   Stall counts follow the wait state rules of the wrapper.
`timescale 1ns/10ps
module cahb_wrapper_tb_top;
    logic        core_clk, rst, gnt, lk, cw;
    logic [31:0] ca;
    logic [1:0]  ck, cs, ct, rs;
    logic [3:0]  ws;
    wire  [31:0] haddr;
    wire  [1:0]  htrans, hresp;
    wire  [2:0]  hsize, hburst;
    wire  [3:0]  hprot;
    wire         hready, hgrant, hwrite, hbusreq, hlock, stn, abt, crl;
    logic [41:0] q[$];
    int          n_mismatch = 0;
    int          comparisons = 0;
    cahb_wrapper cahb_wrapper_i (.core_clk(core_clk), .bus_reset_n(!rst),
        .hready(hready), .hresp(hresp), .hgrant(hgrant), .core_addr(ca),
        .core_access_kind(ck), .core_size(cs), .core_trans(ct),
        .core_write(cw), .core_lock(lk), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hburst(hburst), .hprot(hprot),
        .hbusreq(hbusreq), .hlock(hlock), .core_stall_n(stn),
        .core_abort(abt), .core_reset_low(crl));
    cahb_bus_model cahb_bus_model_i (.hclk(core_clk), .hresetn(!rst),
        .htrans(htrans), .hlock(hlock), .gnt_req(gnt), .waits(ws),
        .resp_sel(rs), .hready(hready), .hresp(hresp), .hgrant(hgrant));
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [41:0] s, input logic [41:0] e);
        comparisons++;
        if (s !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    function logic [41:0] ph(input logic [1:0] t);
        ph = {ca, t, cw, cs == 2'h0 ? 3'h0 : cs == 2'h1 ? 3'h1 : 3'h2,
              2'h0, ck};
    endfunction
    always @(posedge core_clk) begin
        if (!rst && hready === 1'b1 && htrans[1] === 1'b1) begin
            if (q.size() == 0) chk("phase", 1, 0);
            else chk("phase", {haddr, htrans, hwrite, hsize, hprot}, q.pop_front());
        end
    end
    // Mode 1 is a swap read, mode 2 a locked write; gl delays the grant.
    task acc(input logic [1:0] r, input int md, input int bt, input int gl);
        int n, e, i;
        ca <= $urandom & 32'hffff_fffc;
        ck <= $urandom;
        cs <= $urandom;
        cw <= (md == 1) ? 1'b0 : (md == 2) ? 1'b1 : $urandom;
        lk <= (md != 0);
        ct <= 2'h2;
        rs <= r;
        ws <= $urandom % 3;
        gnt <= (gl == 0);
        @(posedge core_clk);
        for (i = 0; i < bt; i++) begin
            q.push_back(ph(i == 0 ? 2'h2 : 2'h3));
            if (r[1]) q.push_back(ph(2'h2));
            // The write of a locked pair is a swap access: no extra wait.
            e = (i == 0 && md != 2 ? 3 : 2) + (md == 1) +
                ((r != 0 && ws == 0) ? 1 : ws);
            ca <= ca + 4;
            ct <= (i + 1 < bt) ? 2'h3 : 2'h0;
            n = 0;
            do begin
                @(posedge core_clk);
                n++;
                if (hresp !== 2'h0) rs <= 2'h0;
                if (n == gl) begin
                    gnt <= 1'b1;
                    chk("busreq", {hbusreq, htrans}, 3'h4);
                end
            end while (stn !== 1'b1 && n < 300);
            if (n >= 300) begin
                n_mismatch++;
                report_and_stop;
            end
            if (!r[1] && gl == 0) chk("stall", n - 1, e);
            chk("abort", abt, i == 0 && r == 2'h1);
            if (md != 0) chk("lock", hlock, 1);
            r = 2'h0;
        end
    endtask
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        {rst, gnt, lk, cw, ca, ck, cs, ct, rs, ws} = {3'h6, 45'h0};
        void'($urandom(2785));
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk("reset_low", crl, 1);
        repeat (12) acc(2'h0, 0, 1 + $urandom % 3, 0);
        $display("test random done");
        for (int r = 1; r < 4; r++) acc(r, 0, 1, 0);
        $display("test responses done");
        acc(2'h0, 1, 1, 0);
        acc(2'h0, 2, 1, 0);
        lk <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk("unlock", hlock, 0);
        acc(2'h0, 0, 1, 5);
        $display("test lock grant done");
        for (int t = 0; t < 2; t++) begin
            ct <= t;
            repeat (4) begin
                @(posedge core_clk);
                chk("idle", {htrans, stn}, 3'h1);
            end
        end
        $display("test idle done");
        ct <= 2'h2;
        repeat (2) @(posedge core_clk);
        rst <= 1'b1;
        ct <= 2'h0;
        #1;
        chk("reset", {htrans, hbusreq, hlock, stn, abt, crl, haddr},
            39'h04_0000_0000);
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        acc(2'h0, 0, 2, 0);
        $display("test reset done");
        report_and_stop;
    end
endmodule // cahb_wrapper_tb_top
